// >>> common/sasm_hist_if.sv
`default_nettype none
interface sasm_hist_if #(
  parameter int AW = 4,
  parameter int DW = 12
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> common/sasm_pkg.sv
// Notes on behaviour
// - forced alarm 87.0: clearable, emergency stop, not logged to history.
// - alarms with history attribute are stored in diagnosis entries 06h to 13h.
// - overload alarm clearable only about 10 s after it occurs; clear waits.
// - absolute counter over and over-speed alarms refuse clear until absolute clear.
// - config bits 0..2 give clear attribute of the three retract alarms.
// - during retract the retract alarm is raised after retracting, then stops.
// - each fieldbus error overwrites status code and slave state.
// - displayed alarm number is the first detected, held until cleared.
// - listed illegal state transitions raise invalid-transition alarm 80.0.
// - invalid transition reports status code 0011h.
// - invalid-transition alarm is clearable; error indicator blinks while active.
// - command error alarm 2 (91.3): clearable, no stop, logged.
// - home return error alarm 2 (94.3): clearable, no stop, logged.
// - motor auto-recognition alarms 95.0-95.4: unclearable, no stop, not logged.
// - encoder data recovery alarm 92.0: unclearable, no stop, logged.
// - requested state codes other than 1,2,3,4,8 raise undefined-request alarm.
`default_nettype none
package sasm_pkg;
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned OVL_CLEAR_TIME_S = 10;
  localparam int unsigned OVL_CLEAR_CYCLES = OVL_CLEAR_TIME_S * CLK_FREQ_HZ;
  localparam int unsigned BLINK_TIME_MS = 200;
  localparam int unsigned BLINK_CYCLES = BLINK_TIME_MS * (CLK_FREQ_HZ / 1000);

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RETRACT_CFG = 8'h04;
  localparam logic [7:0] REG_ALARM = 8'h08;
  localparam logic [7:0] REG_ESM = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_HIST_SEL = 8'h18;
  localparam logic [7:0] REG_HIST_DATA = 8'h1C;
  localparam logic [7:0] REG_HIST_CNT = 8'h20;
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_ABS_CLEAR_BIT = 1;
  localparam logic [2:0] RETRACT_CFG_RST = 3'h0;
  localparam int IRQ_W = 3;
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_ESM_BIT = 1;
  localparam int IRQ_CLEARED_BIT = 2;

  // alarm numbers, main in decimal shown beside
  localparam logic [7:0] ALM_MAIN_OVERLOAD = 8'h10; // 16
  localparam logic [7:0] ALM_MAIN_ABS_CNT = 8'h28;  // 40
  localparam logic [7:0] ALM_MAIN_ABS_SPD = 8'h2A;  // 42
  localparam logic [7:0] ALM_MAIN_FBUS = 8'h50;     // 80
  localparam logic [7:0] ALM_MAIN_RETRACT = 8'h57;  // 87
  localparam logic [7:0] ALM_MAIN_CMD = 8'h5B;      // 91
  localparam logic [7:0] ALM_MAIN_ENC_REC = 8'h5C;  // 92
  localparam logic [7:0] ALM_MAIN_HOME = 8'h5E;     // 94
  localparam logic [7:0] ALM_MAIN_MOTOR_ID = 8'h5F; // 95
  localparam logic [3:0] SUB_FORCED = 4'h0;
  localparam logic [3:0] SUB_RETRACT_IO = 4'h1;
  localparam logic [3:0] SUB_RETRACT_COMM = 4'h2;
  localparam logic [3:0] SUB_RETRACT_FAIL = 4'h3;
  localparam logic [3:0] SUB_CMD2 = 4'h3;
  localparam logic [3:0] SUB_HOME2 = 4'h3;
  localparam logic [3:0] SUB_MOTOR_ID_MAX = 4'h4;
  localparam logic [3:0] SUB_INVALID_TR = 4'h0;
  localparam logic [3:0] SUB_UNDEF_REQ = 4'h1;

  localparam logic [15:0] AL_CODE_NONE = 16'h0000;
  localparam logic [15:0] AL_CODE_INVALID_TR = 16'h0011;
  localparam logic [15:0] AL_CODE_UNDEF_REQ = 16'h0012;
  localparam logic [3:0] ESM_INIT = 4'h1;
  localparam logic [3:0] ESM_PREOP = 4'h2;
  localparam logic [3:0] ESM_BOOT = 4'h3;
  localparam logic [3:0] ESM_SAFEOP = 4'h4;
  localparam logic [3:0] ESM_OP = 4'h8;

  localparam logic [7:0] HIST_FIRST_SUBIDX = 8'h06;
  localparam logic [7:0] HIST_LAST_SUBIDX = 8'h13;
  localparam int HIST_DEPTH = int'(HIST_LAST_SUBIDX) - int'(HIST_FIRST_SUBIDX) + 1;
  localparam int HIST_AW = 4;
  localparam int HIST_DW = 12;

  typedef enum logic [1:0] {
    ALM_IDLE = 2'b00,
    ALM_ACTIVE = 2'b01,
    ALM_PEND = 2'b11
  } sasm_alm_state_type;

  typedef struct packed {
    logic clearable;
    logic estop;
    logic history;
  } sasm_attr_type;
endpackage
`default_nettype wire

// >>> hdl/sasm_core.sv
// The address map and the plain strobed port were decided locally.
`default_nettype none
module sasm_core #(
  parameter int unsigned OVL_CYCLES = sasm_pkg::OVL_CLEAR_CYCLES,
  parameter int unsigned BLINK_HALF = sasm_pkg::BLINK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [sasm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sasm_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [sasm_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_alarm_evt,
  input wire logic [7:0] i_alarm_main,
  input wire logic [3:0] i_alarm_sub,
  input wire logic i_retract_busy,
  input wire logic i_req_evt,
  input wire logic [3:0] i_req_state,
  output logic o_alarm_active,
  output logic [7:0] o_alarm_main,
  output logic [3:0] o_alarm_sub,
  output logic o_estop,
  output logic [15:0] o_al_status_code,
  output logic [3:0] o_al_state,
  output logic o_err_led,
  output logic o_irq
);
  import sasm_pkg::*;

  localparam int OVL_W = $clog2(OVL_CYCLES + 1);
  localparam int BLK_W = $clog2(BLINK_HALF + 1);
  localparam logic [OVL_W-1:0] OVL_LIMIT = OVL_W'(OVL_CYCLES);
  localparam logic [BLK_W-1:0] BLK_LAST = BLK_W'(BLINK_HALF - 1);
  localparam logic [HIST_AW-1:0] HIST_LAST = HIST_AW'(HIST_DEPTH - 1);
  localparam logic [HIST_AW:0] HIST_FULL = (HIST_AW + 1)'(HIST_DEPTH);

  function automatic sasm_attr_type attr_of(input logic [7:0] m, input logic [3:0] s, input logic [2:0] cfg);
    sasm_attr_type a;
    a = '{clearable: 1'b0, estop: 1'b0, history: 1'b1};
    case (m)
      ALM_MAIN_RETRACT: begin
        a.estop = 1'b1;
        case (s)
          SUB_FORCED: begin
            a.clearable = 1'b1;
            a.history = 1'b0;
          end
          SUB_RETRACT_IO: a.clearable = cfg[0];
          SUB_RETRACT_COMM: a.clearable = cfg[1];
          SUB_RETRACT_FAIL: a.clearable = cfg[2];
          default: a.estop = 1'b0;
        endcase
      end
      ALM_MAIN_CMD: a.clearable = (s == SUB_CMD2) || (s == 4'h1);
      ALM_MAIN_HOME: a.clearable = (s == SUB_HOME2);
      ALM_MAIN_ENC_REC: a.clearable = 1'b0;
      ALM_MAIN_MOTOR_ID: a.history = (s > SUB_MOTOR_ID_MAX);
      ALM_MAIN_OVERLOAD: a.clearable = 1'b1;
      ALM_MAIN_ABS_CNT: a.clearable = 1'b1;
      ALM_MAIN_ABS_SPD: a.clearable = 1'b1;
      ALM_MAIN_FBUS: begin
        a.clearable = 1'b1;
        a.history = 1'b0;
      end
      default: a.clearable = 1'b0;
    endcase
    return a;
  endfunction

  sasm_hist_if #(.AW(HIST_AW), .DW(HIST_DW)) hist ();

  sasm_hist_mem #(.DEPTH(HIST_DEPTH), .AW(HIST_AW), .DW(HIST_DW)) u_hist_mem (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .hist(hist.mem)
  );

  sasm_alm_state_type alm_reg;
  sasm_attr_type attr_reg;
  logic [7:0] main_reg;
  logic [3:0] sub_reg;
  logic [2:0] cfg_reg;
  logic abs_done_reg;
  logic [OVL_W-1:0] ovl_cnt_reg;
  logic pend_reg;
  logic [7:0] pend_main_reg;
  logic [3:0] pend_sub_reg;
  logic [3:0] esm_reg;
  logic [15:0] code_reg;
  logic [BLK_W-1:0] blk_cnt_reg;
  logic led_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [HIST_AW-1:0] hist_sel_reg;
  logic [HIST_AW-1:0] hist_ptr_reg;
  logic [HIST_AW:0] hist_cnt_reg;
  logic hist_wr_reg;
  logic [HIST_DW-1:0] hist_data_reg;
  logic [DATA_W-1:0] rdata_reg;

  // fieldbus state request check
  logic req_defined;
  logic req_illegal;
  logic esm_err;
  logic [15:0] esm_code;
  logic [3:0] esm_next;
  always_comb begin
    req_defined = (i_req_state == ESM_INIT) || (i_req_state == ESM_PREOP) || (i_req_state == ESM_BOOT)
                  || (i_req_state == ESM_SAFEOP) || (i_req_state == ESM_OP);
    case (esm_reg)
      ESM_INIT: req_illegal = (i_req_state == ESM_SAFEOP) || (i_req_state == ESM_OP);
      ESM_PREOP: req_illegal = (i_req_state == ESM_OP) || (i_req_state == ESM_BOOT);
      ESM_SAFEOP: req_illegal = (i_req_state == ESM_BOOT);
      ESM_OP: req_illegal = (i_req_state == ESM_BOOT);
      ESM_BOOT: req_illegal = (i_req_state != ESM_INIT);
      default: req_illegal = 1'b0;
    endcase
    esm_err = i_req_evt && (!req_defined || req_illegal);
    esm_code = req_defined ? AL_CODE_INVALID_TR : AL_CODE_UNDEF_REQ;
    esm_next = (esm_reg == ESM_OP) ? ESM_SAFEOP : esm_reg;
  end

  // slave state and status code track the latest fieldbus error
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      esm_reg <= ESM_INIT;
      code_reg <= AL_CODE_NONE;
    end else if (esm_err) begin
      esm_reg <= esm_next;
      code_reg <= esm_code;
    end else if (i_req_evt) begin
      esm_reg <= i_req_state;
    end
  end

  // bus strobes
  logic wr_ctrl;
  logic clear_cmd;
  logic abs_cmd;
  assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
  assign clear_cmd = wr_ctrl && i_wdata[CTRL_CLEAR_BIT];
  assign abs_cmd = wr_ctrl && i_wdata[CTRL_ABS_CLEAR_BIT];

  // external alarms wait at least one cycle in a holding slot so a fieldbus error in the same cycle is not lost
  logic pend_retract;
  logic ext_raise;
  logic raise;
  logic [7:0] raise_main;
  logic [3:0] raise_sub;
  sasm_attr_type raise_attr;
  assign pend_retract = (pend_main_reg == ALM_MAIN_RETRACT) && (pend_sub_reg != SUB_FORCED);
  assign ext_raise = pend_reg && !esm_err && !(pend_retract && i_retract_busy);
  assign raise = esm_err || ext_raise;
  assign raise_main = esm_err ? ALM_MAIN_FBUS : pend_main_reg;
  assign raise_sub = esm_err ? (req_defined ? SUB_INVALID_TR : SUB_UNDEF_REQ) : pend_sub_reg;
  assign raise_attr = attr_of(raise_main, raise_sub, cfg_reg);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_reg <= 1'b0;
      pend_main_reg <= 8'h00;
      pend_sub_reg <= 4'h0;
    end else if (i_alarm_evt && (!pend_reg || ext_raise)) begin
      pend_reg <= 1'b1;
      pend_main_reg <= i_alarm_main;
      pend_sub_reg <= i_alarm_sub;
    end else if (ext_raise) begin
      pend_reg <= 1'b0;
    end
  end

  // clear qualification
  logic is_ovl;
  logic is_abs;
  logic ovl_ok;
  logic can_clear;
  logic do_clear;
  assign is_ovl = (main_reg == ALM_MAIN_OVERLOAD) && (sub_reg == 4'h0);
  assign is_abs = ((main_reg == ALM_MAIN_ABS_CNT) || (main_reg == ALM_MAIN_ABS_SPD)) && (sub_reg == 4'h0);
  assign ovl_ok = (ovl_cnt_reg >= OVL_LIMIT);
  assign can_clear = attr_reg.clearable && (!is_ovl || ovl_ok) && (!is_abs || abs_done_reg);
  assign do_clear = ((alm_reg == ALM_ACTIVE) && clear_cmd && can_clear) || ((alm_reg == ALM_PEND) && can_clear);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      alm_reg <= ALM_IDLE;
      main_reg <= 8'h00;
      sub_reg <= 4'h0;
      attr_reg <= '0;
    end else begin
      case (alm_reg)
        ALM_IDLE: begin
          if (raise) begin
            alm_reg <= ALM_ACTIVE;
            main_reg <= raise_main;
            sub_reg <= raise_sub;
            attr_reg <= raise_attr;
          end
        end
        ALM_ACTIVE: begin
          if (do_clear) begin
            alm_reg <= ALM_IDLE;
          end else if (clear_cmd && attr_reg.clearable && is_ovl) begin
            alm_reg <= ALM_PEND;
          end
          // unclearable, or absolute alarm without absolute clear: command dropped
          if (raise && raise_attr.estop) begin
            attr_reg.estop <= 1'b1;
          end
        end
        ALM_PEND: begin
          if (do_clear) begin
            alm_reg <= ALM_IDLE;
          end
          if (raise && raise_attr.estop) begin
            attr_reg.estop <= 1'b1;
          end
        end
        default: alm_reg <= ALM_IDLE;
      endcase
    end
  end

  // overload clear timer and absolute-clear latch restart with every newly captured alarm
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ovl_cnt_reg <= '0;
    end else if (alm_reg == ALM_IDLE) begin
      ovl_cnt_reg <= '0;
    end else if (is_ovl && !ovl_ok) begin
      ovl_cnt_reg <= ovl_cnt_reg + OVL_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      abs_done_reg <= 1'b0;
    end else if (alm_reg == ALM_IDLE) begin
      abs_done_reg <= 1'b0;
    end else if (abs_cmd) begin
      abs_done_reg <= 1'b1;
    end
  end

  // history ring: every alarm flagged for history is logged, not only the first
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      hist_wr_reg <= 1'b0;
      hist_data_reg <= '0;
      hist_ptr_reg <= '0;
      hist_cnt_reg <= '0;
    end else begin
      hist_wr_reg <= raise && raise_attr.history;
      if (raise && raise_attr.history) begin
        hist_data_reg <= {raise_sub, raise_main};
      end
      if (hist_wr_reg) begin
        hist_ptr_reg <= (hist_ptr_reg == HIST_LAST) ? '0 : hist_ptr_reg + HIST_AW'(1);
        if (hist_cnt_reg != HIST_FULL) begin
          hist_cnt_reg <= hist_cnt_reg + (HIST_AW + 1)'(1);
        end
      end
    end
  end
  assign hist.wr_en = hist_wr_reg;
  assign hist.wr_addr = hist_ptr_reg;
  assign hist.wr_data = hist_data_reg;
  assign hist.rd_addr = hist_sel_reg;

  // blink divider gives a one-cycle toggle enable
  logic blk_tick;
  logic fbus_alarm;
  assign blk_tick = (blk_cnt_reg == BLK_LAST);
  assign fbus_alarm = (alm_reg != ALM_IDLE) && (main_reg == ALM_MAIN_FBUS);
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      blk_cnt_reg <= '0;
    end else if (blk_tick) begin
      blk_cnt_reg <= '0;
    end else begin
      blk_cnt_reg <= blk_cnt_reg + BLK_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      led_reg <= 1'b0;
    end else if (!fbus_alarm) begin
      led_reg <= 1'b0;
    end else if (blk_tick) begin
      led_reg <= !led_reg;
    end
  end

  // configuration, mask and interrupt status; a new event beats a same-cycle write-one clear
  logic [IRQ_W-1:0] irq_set;
  assign irq_set = {do_clear, esm_err, raise && (alm_reg == ALM_IDLE)};
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg <= RETRACT_CFG_RST;
      irq_mask_reg <= '0;
      hist_sel_reg <= '0;
    end else if (i_wr) begin
      case (i_addr)
        REG_RETRACT_CFG: cfg_reg <= i_wdata[2:0];
        REG_IRQ_MASK: irq_mask_reg <= i_wdata[IRQ_W-1:0];
        REG_HIST_SEL: hist_sel_reg <= i_wdata[HIST_AW-1:0];
        default: hist_sel_reg <= hist_sel_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((i_wr && (i_addr == REG_IRQ_STAT)) ? i_wdata[IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= '0;
    end else if (i_rd) begin
      case (i_addr)
        REG_RETRACT_CFG: rdata_reg <= {29'h0, cfg_reg};
        REG_ALARM: rdata_reg <= {12'h000, sub_reg, main_reg, 3'h0, alm_reg == ALM_PEND,
                                 attr_reg.history, attr_reg.estop, attr_reg.clearable, alm_reg != ALM_IDLE};
        REG_ESM: rdata_reg <= {code_reg, 12'h000, esm_reg};
        REG_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
        REG_IRQ_MASK: rdata_reg <= {29'h0, irq_mask_reg};
        REG_HIST_SEL: rdata_reg <= {28'h0, hist_sel_reg};
        REG_HIST_DATA: rdata_reg <= {20'h0, hist.rd_data};
        REG_HIST_CNT: rdata_reg <= {23'h0, hist_ptr_reg, hist_cnt_reg};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // outputs registered
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm_active <= 1'b0;
      o_alarm_main <= 8'h00;
      o_alarm_sub <= 4'h0;
      o_estop <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_alarm_active <= (alm_reg != ALM_IDLE);
      o_alarm_main <= main_reg;
      o_alarm_sub <= sub_reg;
      o_estop <= (alm_reg != ALM_IDLE) && attr_reg.estop;
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
  assign o_rdata = rdata_reg;
  assign o_al_status_code = code_reg;
  assign o_al_state = esm_reg;
  assign o_err_led = led_reg;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  forced_attr_a: assert property (
    (alm_reg == ALM_IDLE) && raise && (raise_main == ALM_MAIN_RETRACT) && (raise_sub == SUB_FORCED)
    |=> attr_reg.clearable && attr_reg.estop && !hist_wr_reg)
    else $error("forced alarm attributes wrong");
  hist_log_a: assert property (
    raise && raise_attr.history |=> hist_wr_reg && (hist_data_reg == {$past(raise_sub), $past(raise_main)}))
    else $error("history entry not written");
  ovl_hold_a: assert property (
    (alm_reg != ALM_IDLE) && is_ovl && (ovl_cnt_reg < OVL_LIMIT) |=> (alm_reg != ALM_IDLE))
    else $error("overload cleared too early");
  abs_refuse_a: assert property (
    (alm_reg != ALM_IDLE) && is_abs && !abs_done_reg |=> (alm_reg != ALM_IDLE))
    else $error("absolute alarm cleared without absolute clear");
  retract_cfg_a: assert property (
    (alm_reg == ALM_IDLE) && raise && (raise_main == ALM_MAIN_RETRACT) && (raise_sub == SUB_RETRACT_COMM)
    |=> attr_reg.clearable == $past(cfg_reg[1]))
    else $error("retract clear attribute ignores config");
  retract_wait_a: assert property (
    pend_reg && pend_retract && i_retract_busy |=> pend_reg && $stable(pend_sub_reg))
    else $error("retract alarm raised during retracting");
  status_upd_a: assert property (
    esm_err |=> (o_al_status_code == $past(esm_code)) ##1 (o_al_status_code == $past(esm_code, 2)) || $past(esm_err))
    else $error("status code not updated");
  first_hold_a: assert property (
    (alm_reg != ALM_IDLE) && !do_clear |=> $stable(main_reg) ##1 (o_alarm_main == $past(main_reg)))
    else $error("first alarm number not held");
  op_fall_a: assert property (
    esm_err && (esm_reg == ESM_OP) && req_defined |=> (o_al_state == ESM_SAFEOP) && (o_al_status_code == AL_CODE_INVALID_TR))
    else $error("invalid request in OP did not fall to SafeOP");
  init_stay_a: assert property (
    i_req_evt && (esm_reg == ESM_INIT) && (i_req_state == ESM_OP) |=> (o_al_state == ESM_INIT))
    else $error("illegal transition from Init accepted");
  led_off_a: assert property (
    !fbus_alarm [*2] |-> !o_err_led)
    else $error("indicator on without fieldbus alarm");
  unclear_ign_a: assert property (
    (alm_reg == ALM_ACTIVE) && clear_cmd && !attr_reg.clearable |=> (alm_reg == ALM_ACTIVE) && $stable(main_reg))
    else $error("unclearable alarm was cleared");

  clear_seen_c: cover property ((alm_reg == ALM_ACTIVE) ##1 (alm_reg == ALM_IDLE));
  pend_seen_c: cover property ((alm_reg == ALM_PEND) ##[1:1000] (alm_reg == ALM_IDLE));
  blink_seen_c: cover property (fbus_alarm && $rose(o_err_led));
  undef_seen_c: cover property (esm_err && !req_defined);
endmodule // sasm_core
`default_nettype wire

// >>> hdl/sasm_hist_mem.sv
`default_nettype none
module sasm_hist_mem #(
  parameter int DEPTH = 14,
  parameter int AW = 4,
  parameter int DW = 12
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  sasm_hist_if.mem hist
);
  logic [DW-1:0] mem_reg [DEPTH];

  always_ff @(posedge i_clk_sys) begin
    if (hist.wr_en && (int'(hist.wr_addr) < DEPTH)) begin
      mem_reg[hist.wr_addr] <= hist.wr_data;
    end
  end

  // out-of-range entries read as zero; unwritten entries are not cleared by reset, so software checks the count
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      hist.rd_data <= '0;
    end else if (int'(hist.rd_addr) < DEPTH) begin
      hist.rd_data <= mem_reg[hist.rd_addr];
    end else begin
      hist.rd_data <= '0;
    end
  end
endmodule // sasm_hist_mem
`default_nettype wire

// >>> verif/sasm_core_tb.sv
`default_nettype none
module sasm_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sasm_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, aev = 0, busy = 0, go = 0, rev, act, es, led, irq;
  logic [7:0] addr = 0, am = 0, om;
  logic [3:0] as = 0, code = 0, rs, os, st;
  logic [31:0] wd = 0, rdat, d;
  logic [15:0] alc;
  logic [3:0] fr [10] = '{ESM_INIT, ESM_INIT, ESM_PREOP, ESM_PREOP, ESM_SAFEOP, ESM_OP,
    ESM_BOOT, ESM_BOOT, ESM_BOOT, ESM_BOOT};
  logic [3:0] tg [10] = '{ESM_SAFEOP, ESM_OP, ESM_OP, ESM_BOOT, ESM_BOOT, ESM_BOOT,
    ESM_BOOT, ESM_PREOP, ESM_SAFEOP, ESM_OP};
  int miscompares = 0, checks = 0, cnt = 0;
  initial forever #50 clk = ~clk;
  sasm_host_model i_sasm_host_model (.i_clk_sys(clk), .i_go(go), .i_code(code), .o_req_evt(rev),
    .o_req_state(rs));
  // short counts keep the overload wait and blink period inside a brief run
  sasm_core #(.OVL_CYCLES(20), .BLINK_HALF(4)) i_sasm_core (.i_clk_sys(clk), .i_resetn(rstn),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_alarm_evt(aev),
    .i_alarm_main(am), .i_alarm_sub(as), .i_retract_busy(busy), .i_req_evt(rev), .i_req_state(rs),
    .o_alarm_active(act), .o_alarm_main(om), .o_alarm_sub(os), .o_estop(es), .o_al_status_code(alc),
    .o_al_state(st), .o_err_led(led), .o_irq(irq));
  task automatic wrap_up();
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (cnt == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) {addr, wd, wr} <= {a, v, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 v = rdat;
  endtask
  task automatic alarm(input logic [7:0] m, input logic [3:0] s);
    @(posedge clk) {aev, am, as} <= {1'b1, m, s};
    @(posedge clk) aev <= 1'b0;
    cyc(4);
  endtask
  task automatic req(input logic [3:0] c);
    @(posedge clk) {go, code} <= {1'b1, c};
    @(posedge clk) go <= 1'b0;
    cyc(4);
  endtask
  task automatic clr();
    wreg(REG_CTRL, 32'h0000_0001);
    cyc(3);
  endtask
  task automatic rst();
    @(posedge clk) rstn <= 1'b0;
    cyc(2);
    @(posedge clk) rstn <= 1'b1;
    cyc(1);
  endtask
  task automatic walk(input logic [3:0] s);
    if (s == ESM_BOOT) req(ESM_BOOT);
    if (s == ESM_PREOP || s == ESM_SAFEOP || s == ESM_OP) req(ESM_PREOP);
    if (s == ESM_SAFEOP || s == ESM_OP) req(ESM_SAFEOP);
    if (s == ESM_OP) req(ESM_OP);
  endtask
  initial begin
    cyc(8);
    @(posedge clk) rstn <= 1'b1;
    cyc(1);
    chk("state", st, ESM_INIT);
    for (int i = 0; i < 10; i++) begin
      rst();
      walk(fr[i]);
      req(tg[i]);
      chk("state", st, (fr[i] == ESM_OP) ? ESM_SAFEOP : fr[i]);
      chk("code", alc, AL_CODE_INVALID_TR);
      chk("alarm", {om, os}, {ALM_MAIN_FBUS, SUB_INVALID_TR});
    end
    wreg(REG_IRQ_MASK, 32'h0000_0001);
    cyc(2);
    chk("irq", irq, 1'b1);
    d[0] = led;
    cyc(4);
    chk("led", led, !d[0]);
    rreg(REG_ESM, d);
    chk("esm", d, {AL_CODE_INVALID_TR, 12'h000, ESM_BOOT});
    req(4'h5);
    chk("code", alc, AL_CODE_UNDEF_REQ);
    chk("alarm", {om, os}, {ALM_MAIN_FBUS, SUB_INVALID_TR});
    clr();
    chk("active", act, 1'b0);
    chk("led", led, 1'b0);
    chk("code", alc, AL_CODE_UNDEF_REQ);
    wreg(REG_IRQ_STAT, 32'h0000_0007);
    cyc(2);
    chk("irq", irq, 1'b0);
    rreg(8'h3C, d);
    chk("unmapped", d, 32'h0000_0000);
    rst();
    rreg(REG_RETRACT_CFG, d);
    chk("cfg", d, 32'h0000_0000);
    alarm(ALM_MAIN_RETRACT, SUB_FORCED);
    chk("estop", es, 1'b1);
    chk("irq", irq, 1'b0);
    alarm(ALM_MAIN_CMD, SUB_CMD2);
    chk("alarm", {om, os}, {ALM_MAIN_RETRACT, SUB_FORCED});
    rreg(REG_HIST_CNT, d);
    chk("count", d[4:0], 5'h01);
    wreg(REG_HIST_SEL, 32'h0000_0000);
    rreg(REG_HIST_DATA, d);
    chk("entry", d[11:0], {SUB_CMD2, ALM_MAIN_CMD});
    clr();
    chk("active", act, 1'b0);
    alarm(ALM_MAIN_CMD, SUB_CMD2);
    chk("estop", es, 1'b0);
    clr();
    chk("active", act, 1'b0);
    alarm(ALM_MAIN_HOME, SUB_HOME2);
    chk("estop", es, 1'b0);
    clr();
    chk("active", act, 1'b0);
    alarm(ALM_MAIN_MOTOR_ID, 4'h2);
    clr();
    chk("active", act, 1'b1);
    chk("estop", es, 1'b0);
    rreg(REG_HIST_CNT, d);
    chk("count", d[4:0], 5'h03);
    rst();
    alarm(ALM_MAIN_ENC_REC, 4'h0);
    clr();
    chk("active", act, 1'b1);
    rreg(REG_HIST_CNT, d);
    chk("count", d[4:0], 5'h01);
    rst();
    alarm(ALM_MAIN_OVERLOAD, 4'h0);
    clr();
    chk("active", act, 1'b1);
    cyc(25);
    chk("active", act, 1'b0);
    for (int i = 0; i < 2; i++) begin
      rst();
      alarm(i ? ALM_MAIN_ABS_SPD : ALM_MAIN_ABS_CNT, 4'h0);
      clr();
      chk("active", act, 1'b1);
      wreg(REG_CTRL, 32'h0000_0002);
      clr();
      chk("active", act, 1'b0);
    end
    rst();
    wreg(REG_RETRACT_CFG, 32'h0000_0001);
    @(posedge clk) busy <= 1'b1;
    alarm(ALM_MAIN_RETRACT, SUB_RETRACT_IO);
    chk("active", act, 1'b0);
    @(posedge clk) busy <= 1'b0;
    cyc(4);
    chk("estop", {act, es}, 2'b11);
    clr();
    chk("active", act, 1'b0);
    rst();
    alarm(ALM_MAIN_RETRACT, SUB_RETRACT_FAIL);
    clr();
    chk("active", act, 1'b1);
    rst();
    wreg(REG_RETRACT_CFG, 32'h0000_0002);
    alarm(ALM_MAIN_RETRACT, SUB_RETRACT_COMM);
    chk("estop", {act, es}, 2'b11);
    clr();
    chk("active", act, 1'b0);
    wrap_up();
  end
endmodule // sasm_core_tb
`default_nettype wire

// >>> verif/sasm_host_model.sv
`default_nettype none
module sasm_host_model (
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic [3:0] i_code,
  output logic o_req_evt,
  output logic [3:0] o_req_state
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_req_evt = 1'b0;
    o_req_state = 4'h0;
  end
  // code flips between requests so a stale value is never mistaken for a request
  always @(posedge i_clk_sys) begin
    o_req_evt <= i_go;
    o_req_state <= i_go ? i_code : ~o_req_state;
  end
endmodule // sasm_host_model
`default_nettype wire
